// File: common/csl_defines.svh
// Offsets, field positions, reset values and timing counts of the command supervision block
`ifndef CSL_DEFINES_SVH
`define CSL_DEFINES_SVH
// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define CSL_CTRL 8'h00
`define CSL_TMO 8'h04
`define CSL_CFG 8'h08
`define CSL_STAT 8'h0c
`define CSL_ISTAT 8'h10
`define CSL_IMSK 8'h14
`define CSL_LIDX 8'h18
`define CSL_LDATA 8'h1c
`define CSL_IND 8'h20
`define CSL_MAP 8'h24
// ----------------------------------------
// Control bit positions
// ----------------------------------------
`define CSL_GO 0
`define CSL_SRC_LO 1
`define CSL_NOFB 3
`define CSL_GI 4
`define CSL_CLR 5
// ----------------------------------------
// Event bits (status and mask layout)
// ----------------------------------------
`define CSL_EV_POS 0
`define CSL_EV_NEG 1
`define CSL_EV_TMO 2
`define CSL_EV_LOG 3
`define CSL_EV_REP 4
// ----------------------------------------
// Reset values, sizes, timing
// ----------------------------------------
`define CSL_TMO_RST 16'h03e8
`define CSL_MAP_RST 24'hfac688
`define CSL_LOG_DEPTH 8'hc8
`define CSL_LOG_LAST 8'hc7
`define CSL_CLK_NS 40
`define CSL_PULSE_NS 1000
`define CSL_PULSE_CYC ((`CSL_PULSE_NS + `CSL_CLK_NS - 1) / `CSL_CLK_NS)
`endif

// File: common/csl_pkg.sv
// Types of the command supervision and event log block
package csl_pkg;
   // Command supervision states
   typedef enum logic [0:0] {CSL_IDLE, CSL_RUN} csl_state_e;
   // Result codes of a finished command
   typedef enum logic [1:0] {CSL_RES_POS, CSL_RES_NEG, CSL_RES_TMO, CSL_RES_NOFB} csl_res_e;
   // Module state apart from the log memory
   typedef struct packed {
      csl_state_e st;
      logic [15:0] tmr;
      logic [7:0] pulse;
      logic [1:0] src;
      logic nofb;
      logic [15:0] tmo;
      logic [7:0] latch_cfg;
      logic [7:0] func_en;
      logic [23:0] map;
      logic [7:0] lidx;
      logic [4:0] ist;
      logic [4:0] imsk;
      logic [7:0] lat;
      logic [7:0] seen;
      logic pk;
      logic [7:0] wptr;
      logic [7:0] cnt;
      csl_res_e res;
      logic cmd_out;
      logic [7:0] outs;
      logic ready;
      logic err;
      logic disp_v;
      logic [1:0] disp_code;
      logic ack_v;
      logic [1:0] ack_src;
      logic [1:0] ack_code;
      logic rep_v;
      logic rep_gi;
      logic [7:0] rep_data;
      logic irq;
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } csl_state_s;
endpackage : csl_pkg

// File: core/csl_core.sv
// Command supervision, indication outputs and operational event log with APB registers
//
// Our own choices: the register addresses and the APB interface to the registers.
`include "csl_defines.svh"
module csl_core (
   input wire logic ref_clk,
   input wire logic arst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic fb_pos,
   input wire logic fb_neg,
   input wire logic [7:0] ind_in,
   input wire logic reset_key,
   input wire logic reset_bin,
   input wire logic pickup,
   input wire logic aux_ok,
   input wire logic self_fault,
   output logic cmd_out,
   output logic [3:0] led_out,
   output logic [3:0] relay_out,
   output logic ready_led,
   output logic error_led,
   output logic disp_valid,
   output logic [1:0] disp_code,
   output logic ack_valid,
   output logic [1:0] ack_src,
   output logic [1:0] ack_code,
   output logic rep_valid,
   output logic rep_gi,
   output logic [7:0] rep_data,
   output logic irq
);
   // ----------------------------------------
   // State, memory, helpers
   // ----------------------------------------
   csl_pkg::csl_state_s q, d; // Registered state and its next value
   logic [15:0] log_mem [0:199]; // Event log storage, battery backed in the product
   logic logw; // Log write strobe
   logic [15:0] logd; // Log write data
   logic [7:0] ind_eff; // Indications of enabled functions only
   logic [7:0] src_v; // Selected source per output
   logic [7:0] lat_v; // Next latched state per output
   logic [7:0] out_v; // Next output level per output
   logic clr; // Any latch reset source
   logic res_v; // Command finished this cycle
   logic [8:0] rp; // Physical log read index
   logic [15:0] rdat; // Log word at the read index

   assign ind_eff = ind_in & q.func_en;

   // ----------------------------------------
   // Per output mapping and latching
   // ----------------------------------------
   for (genvar i = 0; i < 8; i++) begin : g_out
      // Free assignment of any indication
      assign src_v[i] = ind_eff[q.map[3*i +: 3]];
      // Set wins, so an active condition holds the latch
      assign lat_v[i] = src_v[i] | (q.lat[i] & ~clr);
      assign out_v[i] = q.latch_cfg[i] ? lat_v[i] : src_v[i];
   end

   // ----------------------------------------
   // Log read path
   // ----------------------------------------
   always_comb begin
      rp = {1'b0, q.lidx} + ((q.cnt == `CSL_LOG_DEPTH) ? {1'b0, q.wptr} : 9'h000);
      if (rp >= {1'b0, `CSL_LOG_DEPTH}) begin
         rp = rp - {1'b0, `CSL_LOG_DEPTH};
      end
      // Indexes past the fill level read as zero
      rdat = (q.lidx < q.cnt) ? log_mem[rp[7:0]] : 16'h0000;
   end

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb begin
      // Locals: decoded write, setup cycle, pulses, events, changes
      logic wr;
      logic setup;
      logic go;
      logic gi;
      logic [4:0] ev;
      logic [7:0] chg;
      wr = psel & penable & pwrite & q.pready;
      setup = psel & ~penable;
      go = 1'b0;
      gi = 1'b0;
      ev = 5'h00;
      // Changed enabled indications since the last spontaneous report
      chg = ind_eff ^ q.seen;
      d = q;
      d.pready = setup;
      d.pslverr = 1'b0;
      d.disp_v = 1'b0;
      d.ack_v = 1'b0;
      d.rep_v = 1'b0;
      d.rep_gi = 1'b0;
      logw = 1'b0;
      logd = 16'h0000;
      res_v = 1'b0;
      clr = 1'b0;
      // Register writes take effect in the access phase
      if (wr) begin
         case (paddr)
            `CSL_CTRL: begin
               go = pwdata[`CSL_GO];
               gi = pwdata[`CSL_GI];
               clr = pwdata[`CSL_CLR];
               if (q.st == csl_pkg::CSL_IDLE) begin
                  d.src = pwdata[`CSL_SRC_LO +: 2];
                  d.nofb = pwdata[`CSL_NOFB];
               end
            end
            `CSL_TMO: d.tmo = pwdata[15:0];
            `CSL_CFG: begin
               d.latch_cfg = pwdata[7:0];
               d.func_en = pwdata[15:8];
            end
            `CSL_MAP: d.map = pwdata[23:0];
            `CSL_LIDX: d.lidx = pwdata[7:0];
            `CSL_IMSK: d.imsk = pwdata[4:0];
            default: ;
         endcase
      end
      // Read data and error prepared in the setup cycle
      if (setup) begin
         d.prdata = 32'h0000_0000;
         case (paddr)
            `CSL_CTRL: d.prdata = {27'h0, 1'b0, q.nofb, q.src, q.st == csl_pkg::CSL_RUN};
            `CSL_TMO: d.prdata = {16'h0, q.tmo};
            `CSL_CFG: d.prdata = {16'h0, q.func_en, q.latch_cfg};
            `CSL_STAT: d.prdata = {16'h0, q.cnt, 2'b00, q.res, q.err, q.ready, q.cmd_out,
                                   q.st == csl_pkg::CSL_RUN};
            `CSL_ISTAT: d.prdata = {27'h0, q.ist};
            `CSL_IMSK: d.prdata = {27'h0, q.imsk};
            `CSL_LIDX: d.prdata = {24'h0, q.lidx};
            `CSL_LDATA: d.prdata = {16'h0, rdat};
            `CSL_IND: d.prdata = {16'h0, q.lat, ind_eff};
            `CSL_MAP: d.prdata = {8'h0, q.map};
            default: d.pslverr = psel; // Unmapped offsets answer with an error
         endcase
      end
      // Command supervision
      case (q.st)
         csl_pkg::CSL_IDLE: begin
            if (go && !q.err) begin
               d.st = csl_pkg::CSL_RUN;
               d.cmd_out = 1'b1;
               d.tmr = q.tmo;
               d.pulse = 8'(`CSL_PULSE_CYC);
            end
         end
         csl_pkg::CSL_RUN: begin
            d.tmr = q.tmr - 16'h0001;
            if (q.pulse != 8'h00) begin
               d.pulse = q.pulse - 8'h01;
            end
            if (!q.nofb && (fb_pos || fb_neg)) begin
               // Feedback stops the timer; polarity gives the result
               res_v = 1'b1;
               d.res = fb_pos ? csl_pkg::CSL_RES_POS : csl_pkg::CSL_RES_NEG;
            end else if (q.nofb && q.pulse == 8'h01) begin
               res_v = 1'b1;
               d.res = csl_pkg::CSL_RES_NOFB;
            end else if (q.tmr <= 16'h0001) begin
               res_v = 1'b1;
               d.res = csl_pkg::CSL_RES_TMO;
            end
            if (res_v) begin
               d.st = csl_pkg::CSL_IDLE;
               d.cmd_out = 1'b0;
               d.tmr = 16'h0000;
            end
         end
         default: d.st = csl_pkg::CSL_IDLE;
      endcase
      // A finished command is answered towards its source
      if (res_v) begin
         if (q.src == 2'b00) begin
            d.disp_v = 1'b1;
            d.disp_code = d.res;
         end else begin
            d.ack_v = 1'b1;
            d.ack_src = q.src;
            d.ack_code = d.res;
         end
         ev[`CSL_EV_POS] = d.res == csl_pkg::CSL_RES_POS || d.res == csl_pkg::CSL_RES_NOFB;
         ev[`CSL_EV_NEG] = d.res == csl_pkg::CSL_RES_NEG;
         ev[`CSL_EV_TMO] = d.res == csl_pkg::CSL_RES_TMO;
      end
      // Latch reset sources and outputs
      d.pk = pickup;
      clr = clr | reset_key | reset_bin | (pickup & ~q.pk);
      // Power on and the latch reset sources clear latches; a supply dip leaves them alone
      d.lat = lat_v;
      // Ready and error come from the supply (aux_ok) and self check only, no latch reset source touches them
      d.ready = aux_ok & ~self_fault;
      d.err = aux_ok & self_fault;
      d.outs = {out_v[7:4] & {4{~d.err}}, out_v[3:0]};
      // Reports: interrogation wins, a delayed change is retried next cycle
      if (gi) begin
         d.rep_v = 1'b1;
         d.rep_gi = 1'b1;
         d.rep_data = ind_eff;
      end else if (chg != 8'h00 && !res_v) begin
         d.rep_v = 1'b1;
         d.rep_data = ind_eff;
      end
      // One log entry per cycle, command results first
      if (res_v) begin
         logw = 1'b1;
         logd = {4'h2, q.src, d.res, 8'h00};
      end else if (chg != 8'h00 && !gi) begin
         logw = 1'b1;
         logd = {4'h1, 4'h0, ind_eff};
         d.seen = ind_eff;
      end
      if (logw) begin
         ev[`CSL_EV_LOG] = 1'b1;
         d.wptr = (q.wptr == `CSL_LOG_LAST) ? 8'h00 : q.wptr + 8'h01;
         d.cnt = (q.cnt == `CSL_LOG_DEPTH) ? q.cnt : q.cnt + 8'h01;
      end
      ev[`CSL_EV_REP] = d.rep_v;
      // Sticky events, write one clears, a new event wins
      d.ist = q.ist & ~((wr && paddr == `CSL_ISTAT) ? pwdata[4:0] : 5'h00);
      d.ist = d.ist | ev;
      d.irq = (d.ist & q.imsk) != 5'h00;
   end

   // ----------------------------------------
   // Registers; latched state is cleared at power on and by the latch reset sources
   // ----------------------------------------
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         q <= '0;
         q.tmo <= `CSL_TMO_RST;
         q.map <= `CSL_MAP_RST;
         q.func_en <= 8'hff;
      end else begin
         q <= d;
      end
   end

   // Log memory append
   always_ff @(posedge ref_clk) begin
      if (logw) begin
         log_mem[q.wptr] <= logd;
      end
   end

   // ----------------------------------------
   // Outputs straight from flops
   // ----------------------------------------
   assign prdata = q.prdata;
   assign pready = q.pready;
   assign pslverr = q.pslverr;
   assign cmd_out = q.cmd_out;
   assign led_out = q.outs[3:0];
   assign relay_out = q.outs[7:4];
   assign ready_led = q.ready;
   assign error_led = q.err;
   assign disp_valid = q.disp_v;
   assign disp_code = q.disp_code;
   assign ack_valid = q.ack_v;
   assign ack_src = q.ack_src;
   assign ack_code = q.ack_code;
   assign rep_valid = q.rep_v;
   assign rep_gi = q.rep_gi;
   assign rep_data = q.rep_data;
   assign irq = q.irq;

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!arst_n);

   // GO accepted while idle and healthy
   sequence s_issue;
      q.st == csl_pkg::CSL_IDLE && psel && penable && pwrite && q.pready && paddr == `CSL_CTRL
         && pwdata[`CSL_GO] && !q.err;
   endsequence
   // Feedback seen on a running command
   sequence s_fb;
      q.st == csl_pkg::CSL_RUN && !q.nofb && (fb_pos || fb_neg);
   endsequence
   // No-feedback command with monitoring time to spare past its pulse
   sequence s_nofb_start;
      s_issue ##1 (q.nofb && q.tmr > 16'(`CSL_PULSE_CYC));
   endsequence
   // Interrogation pulse taken on the control register
   sequence s_gi;
      psel && penable && pwrite && q.pready && paddr == `CSL_CTRL && pwdata[`CSL_GI];
   endsequence
   // Command still running after this cycle
   sequence s_keep_run;
      q.st == csl_pkg::CSL_RUN && !res_v;
   endsequence

   a_timer_start: assert property (s_issue |=> cmd_out && q.tmr == $past(q.tmo))
      else $error("timer not started with command");
   a_fb_stop: assert property (s_fb |=> !cmd_out && q.st == csl_pkg::CSL_IDLE)
      else $error("feedback did not end command");
   a_tmo_abort: assert property (q.st == csl_pkg::CSL_RUN && !q.nofb && q.tmr == 16'h0001
      && !fb_pos && !fb_neg |=> !cmd_out && q.ist[`CSL_EV_TMO])
      else $error("timeout not flagged");
   a_nofb_end: assert property (s_nofb_start |-> ##(`CSL_PULSE_CYC - 1) cmd_out ##1 !cmd_out)
      else $error("command without feedback not completed");
   a_fb_sign: assert property (s_fb |=> q.res == ($past(fb_pos) ? csl_pkg::CSL_RES_POS
      : csl_pkg::CSL_RES_NEG))
      else $error("feedback polarity lost");
   a_local_disp: assert property ((s_fb and q.src == 2'b00) |=> disp_valid && !ack_valid)
      else $error("local result not on display");
   a_remote_ack: assert property ((s_fb and q.src != 2'b00) |=> ack_valid && ack_src == $past(q.src))
      else $error("acknowledgement not returned");
   a_hold_active: assert property (((q.lat & src_v) & ~d.lat) == 8'h00)
      else $error("active indication cleared");
   a_ready_keep: assert property ($past(arst_n) |-> ready_led == ($past(aux_ok) && !$past(self_fault)))
      else $error("ready indicator wrong");
   a_relay_block: assert property (error_led |-> relay_out == 4'h0)
      else $error("relays not blocked");
   a_log_bound: assert property (q.cnt <= `CSL_LOG_DEPTH)
      else $error("log over capacity");
   a_log_wrap: assert property (q.cnt == `CSL_LOG_DEPTH && logw |=> q.cnt == `CSL_LOG_DEPTH
      && q.wptr != $past(q.wptr))
      else $error("full log did not overwrite oldest");
   a_func_gate: assert property (rep_valid |-> (rep_data & ~$past(q.func_en)) == 8'h00)
      else $error("disabled function reported");
   a_spont_now: assert property ((ind_eff != q.seen) && !res_v |=> rep_valid)
      else $error("spontaneous change not reported");

   // Further guards on clears, timing, reports and log appends
   // Interrogation answers with the whole current picture at once
   a_gi_report: assert property (s_gi |=> rep_valid && rep_gi && rep_data == $past(ind_eff))
      else $error("interrogation not answered");
   // Level reset sources leave only what is still active
   a_latch_clear: assert property (reset_key || reset_bin |=> q.lat == $past(src_v))
      else $error("latch reset ignored");
   // A new pickup clears on its rising edge only
   a_pickup_clear: assert property ($rose(pickup) |=> q.lat == $past(src_v))
      else $error("pickup did not clear latches");
   // Monitoring time counts one step per clock while running
   a_timer_run: assert property (s_keep_run |=> q.st == csl_pkg::CSL_RUN
      && q.tmr == $past(q.tmr) - 16'h0001)
      else $error("monitoring timer stalled");
   // Appending grows the log until it is full
   a_log_append: assert property (logw && q.cnt != `CSL_LOG_DEPTH |=> q.cnt == $past(q.cnt) + 8'h01)
      else $error("log entry not counted");
endmodule : csl_core

// File: dv/csl_switchgear.sv
// Switchgear feedback contact model for the command supervision block
module csl_switchgear (
   input wire logic ref_clk,
   input wire logic arst_n,
   input wire logic cmd_out,
   input wire logic [7:0] fb_delay,
   input wire logic [1:0] fb_kind,
   output logic fb_pos,
   output logic fb_neg
);
   timeunit 1ns;
   timeprecision 1ns;
   // Cycles since the command output rose
   logic [7:0] cnt_q;
   // Contacts close after a delay; kind 2 never answers
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         cnt_q <= 8'h00;
         fb_pos <= 1'b0;
         fb_neg <= 1'b0;
      end else if (!cmd_out) begin
         // Contacts open again once the command drops
         cnt_q <= 8'h00;
         fb_pos <= 1'b0;
         fb_neg <= 1'b0;
      end else begin
         cnt_q <= cnt_q + 8'h01;
         if (cnt_q == fb_delay) begin
            // One contact only, so polarity is unambiguous
            fb_pos <= (fb_kind == 2'h0);
            fb_neg <= (fb_kind == 2'h1);
         end
      end
   end
endmodule : csl_switchgear

// File: dv/command_supervision_event_log_test.sv
// Self-checking bench of the command supervision block
`include "csl_defines.svh"
module command_supervision_event_log_test;
   timeunit 1ns;
   timeprecision 1ns;
   // ----------------------------------------
   // Signals
   // ----------------------------------------
   logic ref_clk = 1'b0;
   logic arst_n = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata;
   logic pready, pslverr, perr;
   logic fb_pos, fb_neg, cmd_out;
   logic [1:0] fb_kind = 2'h0;
   logic [7:0] ind_in = 8'h00;
   logic reset_key = 1'b0, reset_bin = 1'b0, pickup = 1'b0;
   logic aux_ok = 1'b1, self_fault = 1'b0;
   logic [3:0] led_out, relay_out;
   logic ready_led, error_led, disp_valid, ack_valid;
   logic [1:0] disp_code, ack_src, ack_code;
   logic rep_valid, rep_gi, irq;
   logic [7:0] rep_data;
   logic [31:0] r;
   int fails = 0, check_count = 0, cyc = 0;
   // ----------------------------------------
   // Instances and clock
   // ----------------------------------------
   csl_core u_dut (.ref_clk(ref_clk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .fb_pos(fb_pos),
      .fb_neg(fb_neg), .ind_in(ind_in), .reset_key(reset_key), .reset_bin(reset_bin), .pickup(pickup),
      .aux_ok(aux_ok), .self_fault(self_fault), .cmd_out(cmd_out), .led_out(led_out), .relay_out(relay_out),
      .ready_led(ready_led), .error_led(error_led), .disp_valid(disp_valid), .disp_code(disp_code),
      .ack_valid(ack_valid), .ack_src(ack_src), .ack_code(ack_code), .rep_valid(rep_valid), .rep_gi(rep_gi),
      .rep_data(rep_data), .irq(irq));
   csl_switchgear u_gear (.ref_clk(ref_clk), .arst_n(arst_n), .cmd_out(cmd_out), .fb_delay(8'h03),
      .fb_kind(fb_kind), .fb_pos(fb_pos), .fb_neg(fb_neg));
   // 25 MHz clock
   initial begin
      forever #20 ref_clk = ~ref_clk;
   end
   // Watchdog, well above the whole run
   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         fails++;
         stop_test();
      end
   end
   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task automatic stop_test();
      $display("checks %0d mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : stop_test
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      check_count++;
      if (g !== e) begin
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
         fails++;
      end
   endtask : chk
   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk);
   endtask : tick
   // One APB transfer; values read right after the edge are the sampled ones
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
      @(posedge ref_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      // No wait count assumed; only the watchdog ends a stalled wait
      do begin
         @(posedge ref_clk);
      end while (pready !== 1'b1);
      q = prdata;
      perr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   // Issue one command and judge its result, event bit and interrupt
   task automatic cmd(input logic [1:0] src, input logic nofb, input logic [1:0] kind, code, input int d, eb);
      int n;
      fb_kind <= kind;
      apb(1'b1, `CSL_CTRL, {28'h0, nofb, src, 1'b1}, r);
      n = 0;
      do begin
         @(posedge ref_clk);
         n++;
      end while ((disp_valid | ack_valid) !== 1'b1 && n < 100);
      chk("result delay", 1, n >= d && n <= d + 3);
      chk("result code", code, (src == 2'h0) ? disp_code : ack_code);
      chk("display route", src == 2'h0, disp_valid);
      if (src != 2'h0) chk("ack source", src, ack_src);
      tick(1);
      chk("cmd_out after end", 0, cmd_out);
      apb(1'b0, `CSL_ISTAT, 32'h0, r);
      chk("event bit", 1, r[eb]);
      chk("irq raised", 1, irq);
      apb(1'b1, `CSL_ISTAT, 32'h1f, r);
      tick(2);
      chk("irq cleared", 0, irq);
   endtask : cmd
   task automatic wait_rep(input logic gi, input logic [7:0] d);
      int n;
      n = 0;
      do begin
         @(posedge ref_clk);
         n++;
      end while (rep_valid !== 1'b1 && n < 20);
      chk("report seen", 1, rep_valid);
      chk("report kind", gi, rep_gi);
      chk("report data", d, rep_data);
   endtask : wait_rep
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   initial begin
      tick(8);
      arst_n <= 1'b1;
      tick(2);
      // Reset values and an unmapped offset
      apb(1'b0, `CSL_TMO, 32'h0, r);
      chk("tmo reset", 32'h000003e8, r);
      apb(1'b0, `CSL_MAP, 32'h0, r);
      chk("map reset", 32'h00fac688, r);
      apb(1'b0, 8'h28, 32'h0, r);
      chk("unmapped error", 1, perr);
      // Masked event leaves irq low, unmasking raises it
      apb(1'b1, `CSL_IMSK, 32'h0, r);
      ind_in <= 8'h02;
      tick(4);
      chk("irq masked", 0, irq);
      apb(1'b1, `CSL_IMSK, 32'h1f, r);
      tick(2);
      chk("irq unmasked", 1, irq);
      ind_in <= 8'h00;
      apb(1'b1, `CSL_ISTAT, 32'h1f, r);
      // Commands: sources 0 to 2, both polarities, timeout, no feedback
      apb(1'b1, `CSL_TMO, 32'd20, r);
      cmd(2'h0, 1'b0, 2'h0, 2'h0, 3, `CSL_EV_POS);
      cmd(2'h1, 1'b0, 2'h1, 2'h1, 3, `CSL_EV_NEG);
      cmd(2'h2, 1'b0, 2'h0, 2'h0, 3, `CSL_EV_POS);
      apb(1'b1, `CSL_TMO, 32'd10, r);
      cmd(2'h1, 1'b0, 2'h2, 2'h2, 10, `CSL_EV_TMO);
      // A monitoring time shorter than the pulse would end it as a timeout
      apb(1'b1, `CSL_TMO, 32'd40, r);
      cmd(2'h2, 1'b1, 2'h2, 2'h3, 25, `CSL_EV_POS);
      // Latched output 0 against unlatched output 1
      apb(1'b1, `CSL_CFG, 32'h0000ff01, r);
      ind_in <= 8'h01;
      tick(3);
      reset_key <= 1'b1;
      tick(3);
      reset_key <= 1'b0;
      chk("active not cleared", 4'h1, led_out);
      for (int k = 0; k < 4; k++) begin
         ind_in <= 8'h03;
         tick(3);
         ind_in <= 8'h00;
         tick(3);
         chk("latched led", 4'h1, led_out);
         case (k)
            0: reset_key <= 1'b1;
            1: reset_bin <= 1'b1;
            2: apb(1'b1, `CSL_CTRL, 32'h20, r);
            default: pickup <= 1'b1;
         endcase
         tick(2);
         reset_key <= 1'b0;
         reset_bin <= 1'b0;
         pickup <= 1'b0;
         tick(2);
         chk("latch cleared", 4'h0, led_out);
         chk("ready kept", 1, ready_led);
      end
      // Latched output survives a supply dip; ready drops meanwhile
      ind_in <= 8'h01;
      tick(3);
      ind_in <= 8'h00;
      aux_ok <= 1'b0;
      tick(3);
      chk("latch through dip", 4'h1, led_out);
      chk("ready in dip", 0, ready_led);
      aux_ok <= 1'b1;
      reset_key <= 1'b1;
      tick(2);
      reset_key <= 1'b0;
      // Disabled function produces nothing
      apb(1'b1, `CSL_CFG, 32'h0000fe00, r);
      ind_in <= 8'h01;
      tick(3);
      chk("disabled led", 4'h0, led_out);
      apb(1'b0, `CSL_IND, 32'h0, r);
      chk("disabled ind", 8'h00, r[7:0]);
      // Self-check fault
      apb(1'b1, `CSL_CFG, 32'h0000ff00, r);
      ind_in <= 8'h10;
      tick(3);
      chk("relay on", 4'h1, relay_out);
      self_fault <= 1'b1;
      tick(3);
      chk("ready off", 0, ready_led);
      chk("error on", 1, error_led);
      chk("relays blocked", 4'h0, relay_out);
      self_fault <= 1'b0;
      ind_in <= 8'h05;
      wait_rep(1'b0, 8'h05);
      apb(1'b1, `CSL_CTRL, 32'h10, r);
      wait_rep(1'b1, 8'h05);
      // Overfill the event log by five entries
      ind_in <= 8'h00;
      tick(3);
      for (int j = 1; j <= 205; j++) begin
         ind_in <= j[7:0];
         tick(2);
      end
      tick(3);
      apb(1'b0, `CSL_STAT, 32'h0, r);
      chk("log count", `CSL_LOG_DEPTH, r[15:8]);
      apb(1'b1, `CSL_LIDX, 32'h0, r);
      apb(1'b0, `CSL_LDATA, 32'h0, r);
      chk("oldest entry", 32'h00001006, r);
      apb(1'b1, `CSL_LIDX, 32'hc7, r);
      apb(1'b0, `CSL_LDATA, 32'h0, r);
      chk("newest entry", 32'h000010cd, r);
      stop_test();
   end
endmodule : command_supervision_event_log_test
